//--- dv/avc_link_chk.sv
// Checker of the two-wire link between the master and target ends.
// Assumes the link lines only move on i_clk edges.
`timescale 1ns/1ps
`default_nettype none
`include "avc_defs.svh"
module avc_link_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic sda_oe_n_m,
    input wire logic sda_o_d,
    input wire logic sda_oe_n_d,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_r;
    logic       sda_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [7:0] sh_r;
    wire        rise  = scl && !scl_r;
    wire        high  = scl && scl_r;
    wire        start = high && sda_r && !sda;
    wire        stop  = high && !sda_r && sda;
    assign cnt_nxt = start ? 5'h00 : cnt_r + {4'h0, rise};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            cnt_r <= 5'h00;
            sh_r  <= 8'h00;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
            cnt_r <= cnt_nxt;
            sh_r  <= rise ? {sh_r[6:0], sda} : sh_r;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    property p_dev_edge;
        $changed(sda_oe_n_d) |-> !scl;
    endproperty
    a_dev_edge: assert property (p_dev_edge)
        else $error("target moved data with clock high");
    property p_host_edge;
        $changed(sda_oe_n_m) && scl |->
            cnt_r == 5'h00 || cnt_r == 5'h0A || cnt_r == 5'h13;
    endproperty
    a_host_edge: assert property (p_host_edge)
        else $error("master moved data with clock high");
    property p_start;
        start |-> ##[1:12] !scl;
    endproperty
    a_start: assert property (p_start)
        else $error("no clock after start");
    property p_stop;
        stop |=> (scl && sda)[*2];
    endproperty
    a_stop: assert property (p_stop)
        else $error("bus not idle after stop");
    property p_count;
        stop |-> cnt_r == 5'h0A || cnt_r == 5'h13;
    endproperty
    a_count: assert property (p_count)
        else $error("clock pulse count wrong at stop");
    property p_ack;
        high && (cnt_r == 5'h09 || cnt_r == 5'h12) |-> !sda_oe_n_d && !sda;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge pulse not held low");
    property p_free;
        high && cnt_r != 5'h09 && cnt_r < 5'h12 |-> sda_oe_n_d;
    endproperty
    a_free: assert property (p_free)
        else $error("target drove data during a data bit");
    property p_msb;
        cnt_r == 5'h08 && $past(rise) |-> sh_r == {`AVC_DEV_ADDR, 1'b0};
    endproperty
    a_msb: assert property (p_msb)
        else $error("address byte wrong on the wire");
    property p_low;
        !sda_oe_n_d |-> !sda_o_d && !sda;
    endproperty
    a_low: assert property (p_low)
        else $error("target drive did not pull data low");
    c_start: cover property (start);
    c_ack: cover property (high && cnt_r == 5'h12 && !sda);
    c_frame: cover property (stop && cnt_r == 5'h13);
endmodule // avc_link_chk
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench: master and target ends joined on one link.
// Assumes the design files under rtl are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "avc_defs.svh"
`define CHK(n, e, a) chk(n, e, a)
module testbench;
    logic        i_clk;
    logic        i_rst;
    logic        i_go;
    logic [7:0]  i_cmd;
    logic        o_ready;
    logic        o_done;
    logic        o_nack;
    logic        o_busy;
    logic [5:0]  o_vol1;
    logic [5:0]  o_vol2;
    logic [4:0]  o_bass;
    logic [4:0]  o_mid;
    logic [4:0]  o_treb;
    logic [4:0]  o_mux;
    logic [31:0] seed;
    logic [7:0]  c;
    int          i;
    int          error_cnt;
    int          checks_done;
    int          m [6];
    logic [7:0]  am [8] = '{8'h7E, 8'h7F, 8'h1F, 8'h1F, 8'h1F, 8'h1F,
                            8'h00, 8'h00};
    logic [7:0]  om [8] = '{8'h00, 8'h01, 8'h80, 8'hA0, 8'hC0, 8'hE0,
                            8'h7F, 8'h9F};
    avc_if bus ();
    avc_host u_avc_host (.i_clk(i_clk), .i_rst(i_rst), .bus(bus),
        .i_go(i_go), .i_cmd(i_cmd), .o_ready(o_ready), .o_done(o_done),
        .o_nack(o_nack));
    avc_dev u_avc_dev (.i_clk(i_clk), .i_rst(i_rst), .bus(bus),
        .o_vol1(o_vol1), .o_vol2(o_vol2), .o_bass(o_bass), .o_mid(o_mid),
        .o_treb(o_treb), .o_mux(o_mux), .o_busy(o_busy));
    avc_link_chk u_avc_link_chk (.i_clk(i_clk), .i_rst(i_rst),
        .sda_oe_n_m(bus.sda_oe_n_m), .sda_o_d(bus.sda_o_d),
        .sda_oe_n_d(bus.sda_oe_n_d), .scl(bus.scl), .sda(bus.sda));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] a);
        checks_done++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %0h got %0h", n, e, a);
        end
    endtask
    task automatic do_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        m = '{`AVC_VOL_MUTE, `AVC_VOL_MUTE, `AVC_TONE_RESET,
              `AVC_TONE_RESET, `AVC_TONE_RESET, `AVC_MUX_ACTIVE};
    endtask
    task automatic check_all();
        @(negedge i_clk);
        `CHK("vol1", m[0], o_vol1);
        `CHK("vol2", m[1], o_vol2);
        `CHK("treble", m[2], o_treb);
        `CHK("middle", m[3], o_mid);
        `CHK("bass", m[4], o_bass);
        `CHK("mux", m[5], o_mux);
    endtask
    task automatic frame(input logic [7:0] v);
        int n;
        `CHK("ready", 8'h01, o_ready);
        @(posedge i_clk);
        i_go  <= 1'b1;
        i_cmd <= v;
        @(posedge i_clk);
        i_go  <= 1'b0;
        for (n = 0; n < 2000; n++) begin
            @(negedge i_clk);
            if (n == 40) begin
                `CHK("busy", 8'h01, o_busy);
                `CHK("ready", 8'h00, o_ready);
                @(posedge i_clk);
                i_go  <= 1'b1;
                i_cmd <= ~v;
                @(posedge i_clk);
                i_go  <= 1'b0;
            end
            if (o_done === 1'b1) break;
        end
        if (n == 2000) begin
            `CHK("done", 8'h01, o_done);
            stop_test();
        end
        `CHK("nack", 8'h00, o_nack);
        if (!v[7]) m[v[0]] = v[6:1];
        else m[2 + v[6:5]] = v[4:0];
        repeat (4) @(negedge i_clk);
        `CHK("idle", 8'h00, o_busy);
        check_all();
    endtask
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        i_rst = 1'b1;
        i_go = 1'b0;
        i_cmd = 8'h00;
        seed = 32'd68600;
        error_cnt = 0;
        checks_done = 0;
        do_reset();
        check_all();
        for (i = 0; i < 30; i++) begin
            seed = xs(seed);
            c = seed[7:0];
            if (i < 8) c = (c & am[i]) | om[i];
            frame(c);
        end
        @(posedge i_clk);
        i_go  <= 1'b1;
        i_cmd <= 8'h00;
        @(posedge i_clk);
        i_go  <= 1'b0;
        repeat (250) @(posedge i_clk);
        do_reset();
        check_all();
        frame(8'hC5);
        stop_test();
    end
endmodule // testbench
`default_nettype wire

//--- rtl/avc_defs.svh
// Constants of the audio control serial link: address, codes, resets.
// Assumes nothing; included by the package user files by bare name.
`ifndef AVC_DEFS_SVH
`define AVC_DEFS_SVH
`define AVC_DEV_ADDR    7'h43
`define AVC_BYTE_BITS   4'h8
`define AVC_VOL_MUTE    6'h3F
`define AVC_TONE_RESET  5'h1E
`define AVC_MUX_ACTIVE  5'h1F
`define AVC_SCL_HALF    8'h04
`endif

//--- rtl/avc_dev.sv
// Audio control target end: receives writes and holds tone and volume.
// Assumes the link lines are asynchronous and sampled on i_clk.
//
// Operation
// - Master keeps data steady while clock high.
// - Data changes only while clock low.
// - Data fall, clock high: start.
// - Data rise, clock high: stop.
// - Each byte is exactly eight bits.
// - Ninth clock pulse is acknowledge slot.
// - Most significant bit first.
// - Two independent volume settings.
// - Volume steps 1dB down to mute.
// - Bass, middle, treble cut and boost.
// - Drive data low through acknowledge pulse.
// - First byte is address, write bit.
// - Power-on: mute, maximum cut, active input.
`timescale 1ns/1ps
`default_nettype none
`include "avc_defs.svh"
module avc_dev
    import avc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    avc_if.dev              bus,
    output logic [5:0]      o_vol1,
    output logic [5:0]      o_vol2,
    output logic [4:0]      o_bass,
    output logic [4:0]      o_mid,
    output logic [4:0]      o_treb,
    output logic [4:0]      o_mux,
    output logic            o_busy
);
    logic [1:0]     scl_s_r;
    logic [1:0]     sda_s_r;
    logic           scl_d_r;
    logic           sda_d_r;
    avc_dev_state_t st_r;
    logic [7:0]     sh_r;
    logic [3:0]     cnt_r;
    logic           addr_r;
    logic           ack_drv_r;
    logic [5:0]     vol1_r;
    logic [5:0]     vol2_r;
    logic [4:0]     bass_r;
    logic [4:0]     mid_r;
    logic [4:0]     treb_r;
    logic [4:0]     mux_r;

    wire scl_w   = scl_s_r[1];
    wire sda_w   = sda_s_r[1];
    wire scl_rise = scl_w && !scl_d_r;
    wire scl_fall = !scl_w && scl_d_r;
    wire start_w = scl_w && scl_d_r && sda_d_r && !sda_w;
    wire stop_w  = scl_w && scl_d_r && !sda_d_r && sda_w;
    wire [7:0] byte_w = {sh_r[6:0], sda_w};
    wire addr_ok = (sh_r[7:1] == `AVC_DEV_ADDR) && !sh_r[0];

    // Tone and input commands share one format: flag, select, value.
    function automatic logic tone_hit(input logic [7:0] b,
                                      input logic [1:0] sel);
        return b[7] && (b[6:5] == sel);
    endfunction

    wire byte_end = (st_r == AVC_BITS) && scl_fall
                  && (cnt_r == `AVC_BYTE_BITS);
    wire cmd_stb  = byte_end && addr_r;
    wire wr_vol1  = cmd_stb && !sh_r[7] && !sh_r[0];
    wire wr_vol2  = cmd_stb && !sh_r[7] && sh_r[0];
    wire wr_treb  = cmd_stb && tone_hit(sh_r, 2'h0);
    wire wr_mid   = cmd_stb && tone_hit(sh_r, 2'h1);
    wire wr_bass  = cmd_stb && tone_hit(sh_r, 2'h2);
    wire wr_mux   = cmd_stb && tone_hit(sh_r, 2'h3);
    wire [5:0] vol_code  = sh_r[6:1];
    wire [4:0] tone_code = sh_r[4:0];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            vol1_r <= `AVC_VOL_MUTE;
        end else if (wr_vol1) begin
            vol1_r <= vol_code;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            vol2_r <= `AVC_VOL_MUTE;
        end else if (wr_vol2) begin
            vol2_r <= vol_code;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            treb_r <= `AVC_TONE_RESET;
        end else if (wr_treb) begin
            treb_r <= tone_code;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mid_r <= `AVC_TONE_RESET;
        end else if (wr_mid) begin
            mid_r <= tone_code;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bass_r <= `AVC_TONE_RESET;
        end else if (wr_bass) begin
            bass_r <= tone_code;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mux_r <= `AVC_MUX_ACTIVE;
        end else if (wr_mux) begin
            mux_r <= tone_code;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], bus.scl};
            sda_s_r <= {sda_s_r[0], bus.sda};
            scl_d_r <= scl_w;
            sda_d_r <= sda_w;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r      <= AVC_IDLE;
            sh_r      <= 8'h00;
            cnt_r     <= 4'h0;
            addr_r    <= 1'b0;
            ack_drv_r <= 1'b0;
        end else if (start_w) begin
            st_r      <= AVC_BITS;
            cnt_r     <= 4'h0;
            addr_r    <= 1'b0;
            ack_drv_r <= 1'b0;
        end else if (stop_w) begin
            st_r      <= AVC_IDLE;
            ack_drv_r <= 1'b0;
        end else begin
            case (st_r)
                AVC_BITS: begin
                    if (scl_rise) begin
                        sh_r  <= byte_w;
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == `AVC_BYTE_BITS) begin
                        cnt_r <= 4'h0;
                        if (addr_r || addr_ok) begin
                            addr_r    <= 1'b1;
                            ack_drv_r <= 1'b1;
                            st_r      <= AVC_ACK;
                        end else begin
                            st_r <= AVC_SKIP;
                        end
                    end
                end
                AVC_ACK: begin
                    if (scl_fall) begin
                        ack_drv_r <= 1'b0;
                        st_r      <= AVC_BITS;
                    end
                end
                AVC_SKIP: st_r <= AVC_SKIP;
                default:  st_r <= AVC_IDLE;
            endcase
        end
    end

    assign bus.sda_o_d    = 1'b0;
    assign bus.sda_oe_n_d = !ack_drv_r;
    assign o_vol1 = vol1_r;
    assign o_vol2 = vol2_r;
    assign o_bass = bass_r;
    assign o_mid  = mid_r;
    assign o_treb = treb_r;
    assign o_mux  = mux_r;
    assign o_busy = (st_r != AVC_IDLE);
endmodule // avc_dev
`default_nettype wire

//--- rtl/avc_host.sv
// Bus master end: sends one address byte and, if it is acknowledged, one command byte per frame.
// Assumes i_go is a pulse from logic on i_clk; makes the link clock.
`timescale 1ns/1ps
`default_nettype none
`include "avc_defs.svh"
module avc_host
    import avc_pkg::*;
#(
    parameter logic [7:0] HALF = `AVC_SCL_HALF
)(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    avc_if.host             bus,
    input  wire logic       i_go,
    input  wire logic [7:0] i_cmd,
    output logic            o_ready,
    output logic            o_done,
    output logic            o_nack
);
    avc_host_state_t st_r;
    logic [7:0]      div_r;
    logic [1:0]      ph_r;
    logic [7:0]      sh_r;
    logic [7:0]      cmd_r;
    logic [3:0]      cnt_r;
    logic            nbyte_r;
    logic            scl_r;
    logic            sda_r;
    logic            done_r;
    logic            nack_r;
    logic [1:0]      sda_s_r;

    wire tick = (div_r == HALF - 8'h01);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= AVC_H_IDLE;
            div_r <= 8'h00;
            ph_r <= 2'h0;
            sh_r <= 8'h00;
            cmd_r <= 8'h00;
            cnt_r <= 4'h0;
            nbyte_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            sda_s_r <= 2'h3;
        end else begin
            sda_s_r <= {sda_s_r[0], bus.sda};
            done_r <= 1'b0;
            div_r <= (st_r == AVC_H_IDLE || tick) ? 8'h00 : div_r + 8'h01;
            case (st_r)
                AVC_H_IDLE: if (i_go) begin
                    sh_r <= {`AVC_DEV_ADDR, 1'b0};
                    cmd_r <= i_cmd;
                    nbyte_r <= 1'b0;
                    nack_r <= 1'b0;
                    st_r <= AVC_H_START;
                end
                AVC_H_START: if (tick) begin
                    if (!sda_r) begin
                        scl_r <= 1'b0;
                        cnt_r <= 4'h0;
                        ph_r <= 2'h0;
                        st_r <= AVC_H_BIT;
                    end else sda_r <= 1'b0;
                end
                AVC_H_BIT: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_r <= sh_r[7];
                        2'h1: scl_r <= 1'b1;
                        2'h2: begin
                        end
                        default: begin
                            scl_r <= 1'b0;
                            sh_r <= {sh_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == `AVC_BYTE_BITS - 4'h1)
                                st_r <= AVC_H_ACK;
                        end
                    endcase
                end
                AVC_H_ACK: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_r <= 1'b1;
                        2'h1: scl_r <= 1'b1;
                        2'h2: if (sda_s_r[1]) nack_r <= 1'b1;
                        default: begin
                            scl_r <= 1'b0;
                            cnt_r <= 4'h0;
                            sh_r <= cmd_r;
                            nbyte_r <= 1'b1;
                            st_r <= (nbyte_r || nack_r) ?
                                    AVC_H_STOP : AVC_H_BIT;
                        end
                    endcase
                end
                AVC_H_STOP: if (tick) begin
                    ph_r <= ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_r <= 1'b0;
                        2'h1: scl_r <= 1'b1;
                        2'h2: sda_r <= 1'b1;
                        default: st_r <= AVC_H_DONE;
                    endcase
                end
                AVC_H_DONE: begin
                    done_r <= 1'b1;
                    st_r <= AVC_H_IDLE;
                end
                default: st_r <= AVC_H_IDLE;
            endcase
        end
    end

    assign bus.scl_o_m    = 1'b0;
    assign bus.scl_oe_n_m = scl_r;
    assign bus.sda_o_m    = 1'b0;
    assign bus.sda_oe_n_m = sda_r;
    assign o_ready = (st_r == AVC_H_IDLE);
    assign o_done  = done_r;
    assign o_nack  = nack_r;
endmodule // avc_host
`default_nettype wire

//--- rtl/avc_if.sv
// Two-wire link between the bus master and the audio control target.
// Assumes pull-ups: a line is low when any party enables its drive.
`timescale 1ns/1ps
`default_nettype none
interface avc_if;
    logic scl_o_m;
    logic scl_oe_n_m;
    logic sda_o_m;
    logic sda_oe_n_m;
    logic sda_o_d;
    logic sda_oe_n_d;
    logic scl;
    logic sda;
    assign scl = !(scl_oe_n_m == 1'b0 && scl_o_m == 1'b0);
    assign sda = !((sda_oe_n_m == 1'b0 && sda_o_m == 1'b0)
                || (sda_oe_n_d == 1'b0 && sda_o_d == 1'b0));
    modport host (output scl_o_m, output scl_oe_n_m, output sda_o_m,
                  output sda_oe_n_m, input scl, input sda);
    modport dev  (output sda_o_d, output sda_oe_n_d, input scl, input sda);
endinterface
`default_nettype wire

//--- rtl/avc_pkg.sv
// Types shared by both ends of the audio control serial link.
// Assumes the constants header sits beside it.
package avc_pkg;
    typedef enum logic [2:0] {
        AVC_IDLE,
        AVC_BITS,
        AVC_ACK,
        AVC_SKIP
    } avc_dev_state_t;
    typedef enum logic [2:0] {
        AVC_H_IDLE,
        AVC_H_START,
        AVC_H_BIT,
        AVC_H_ACK,
        AVC_H_STOP,
        AVC_H_DONE
    } avc_host_state_t;
endpackage
